// File: rtl/haptic_pkg.sv
// shared constants, types and register map of the haptic drive control block
package haptic_pkg;

	// register byte offsets
	localparam logic [7:0] OFS_CTRL     = 8'h00;
	localparam logic [7:0] OFS_PERIOD   = 8'h04;
	localparam logic [7:0] OFS_AMP      = 8'h08;
	localparam logic [7:0] OFS_SHAPE    = 8'h0C;
	localparam logic [7:0] OFS_RESIST   = 8'h10;
	localparam logic [7:0] OFS_FACTOR   = 8'h14;
	localparam logic [7:0] OFS_STATUS   = 8'h18;
	localparam logic [7:0] OFS_IRQ_STAT = 8'h1C;
	localparam logic [7:0] OFS_IRQ_MASK = 8'h20;

	// playback modes
	typedef enum logic [2:0] {
		MODE_OFF                  = 3'h0,
		DIRECT_OVERRIDE_MODE      = 3'h1,
		MODE_PWM                  = 3'h2,
		REALTIME_MEMORY_PLAYBACK  = 3'h3,
		TRIGGERED_MEMORY_PLAYBACK = 3'h4
	} play_mode_e;

	// drive sequencer states
	typedef enum logic [2:0] {
		ST_IDLE  = 3'b001,
		ST_MEAS  = 3'b010,
		ST_DRIVE = 3'b100
	} drive_state_e;

	// control register layout, bit 14 down to bit 0
	typedef struct packed {
		logic       back_emf_sensing_enable;
		logic       resonance_follow_enable;
		logic       embedded_mode;
		logic       custom_shape_select;
		logic       amplitude_loop_enable;
		logic       resistance_measure_disable;
		logic       drive_factor_hold;
		play_mode_e play_mode;
		logic [4:0] peak_current_limit;
	} ctrl_s;

	// shape scales, 256 equals full peak current
	typedef struct packed {
		logic [7:0] shape_point_three_scale;
		logic [7:0] shape_point_two_scale;
		logic [7:0] shape_point_one_scale;
	} shape_s;

	// memory frame data from the playback engine
	typedef struct packed {
		logic [15:0] period;
		logic        period_valid;
		logic [7:0]  amp;
	} frame_s;

	// output stage command
	typedef struct packed {
		logic        enable;
		logic        loop_enable;
		logic        polarity;
		logic [12:0] level;
	} drive_s;

	// reset values
	localparam ctrl_s       CTRL_RESET   = ctrl_s'(15'h0000);
	localparam shape_s      SHAPE_RESET  = shape_s'(24'hECB461);
	localparam logic [15:0] PERIOD_RESET = 16'h0100;
	localparam logic [7:0]  AMP_RESET    = 8'h00;
	localparam logic [9:0]  FACTOR_RESET = 10'h000;
	localparam logic [2:0]  MASK_RESET   = 3'h0;

	// event bits and misc
	localparam int          EV_SHORT     = 0;
	localparam int          EV_DONE      = 1;
	localparam int          EV_MEAS      = 2;
	localparam logic [2:0]  FAULT_BITS   = 3'h1;
	localparam logic [8:0]  FULL_SCALE   = 9'h100;
	localparam logic [7:0]  BEMF_LIMIT   = 8'hC0;

endpackage

// File: rtl/half_period_gen.sv
// point timer: eight points per half-period, polarity and half-start pulse
`timescale 1ns/100ps
module half_period_gen (
	// clock and reset
	input  wire logic        ref_clk,
	input  wire logic        rst,
	// control
	input  wire logic        run,
	input  wire logic [15:0] point_cycles,
	// timing
	output logic             half_start,
	output logic [2:0]       point_idx,
	output logic             polarity
);
	import haptic_pkg::*;

	logic [15:0] cnt_ff, nxt_cnt, per_ff, nxt_per;
	logic [2:0]  idx_ff, nxt_idx;
	logic        pol_ff, nxt_pol, on_ff, nxt_on, start_ff, nxt_start;

	// new period is only taken at a half-period boundary
	always_comb begin
		nxt_cnt = cnt_ff;
		nxt_per = per_ff;
		nxt_idx = idx_ff;
		nxt_pol = pol_ff;
		nxt_on = on_ff;
		nxt_start = 1'b0;
		if (!run) begin
			nxt_cnt = 16'h0000;
			nxt_idx = 3'h0;
			nxt_pol = 1'b0;
			nxt_on = 1'b0;
		end else if (!on_ff) begin
			nxt_on = 1'b1;
			nxt_per = point_cycles;
			nxt_cnt = point_cycles;
			nxt_start = 1'b1;
		end else if (cnt_ff == 16'h0000) begin
			nxt_idx = idx_ff + 3'h1;
			nxt_cnt = per_ff;
			if (idx_ff == 3'h7) begin
				nxt_pol = ~pol_ff;
				nxt_per = point_cycles;
				nxt_cnt = point_cycles;
				nxt_start = 1'b1;
			end
		end else begin
			nxt_cnt = cnt_ff - 16'h0001;
		end
	end

	// timer state
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			cnt_ff <= 16'h0000;
			per_ff <= PERIOD_RESET;
			idx_ff <= 3'h0;
			pol_ff <= 1'b0;
			on_ff <= 1'b0;
			start_ff <= 1'b0;
		end else begin
			cnt_ff <= nxt_cnt;
			per_ff <= nxt_per;
			idx_ff <= nxt_idx;
			pol_ff <= nxt_pol;
			on_ff <= nxt_on;
			start_ff <= nxt_start;
		end
	end

	assign half_start = start_ff;
	assign point_idx = idx_ff;
	assign polarity = pol_ff;

	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);

	// period only moves with a half-period start
	per_hold_a: assert property ($changed(per_ff) |-> start_ff)
		else $error("period changed mid half-period");
	point_wrap_a: assert property (run && on_ff && idx_ff == 3'h7 && cnt_ff == 16'h0000 |=>
		idx_ff == 3'h0 && start_ff && pol_ff != $past(pol_ff))
		else $error("half-period did not wrap after point 7");
endmodule

// File: rtl/shape_point.sv
// scales drive amplitude by the mirrored custom shape point
`timescale 1ns/100ps
module shape_point (
	// clock and reset
	input  wire logic             ref_clk,
	input  wire logic             rst,
	// shape setup
	input  wire logic             custom,
	input  wire haptic_pkg::shape_s coef,
	input  wire logic [2:0]       point,
	// amplitude
	input  wire logic [7:0]       amp,
	input  wire logic [4:0]       peak,
	output logic [12:0]           level
);
	import haptic_pkg::*;

	logic [12:0] level_ff, nxt_level, base;
	logic [21:0] prod;
	logic [8:0]  frac;

	// fraction of peak for a point, points 5..7 mirror 3..1
	function automatic logic [8:0] point_frac(input logic [2:0] p, input shape_s c);
		logic [2:0] m;
		m = (p > 3'h4) ? 3'h0 - p : p;
		case (m)
			3'h0: point_frac = 9'h000;
			3'h1: point_frac = {1'b0, c.shape_point_one_scale};
			3'h2: point_frac = {1'b0, c.shape_point_two_scale};
			3'h3: point_frac = {1'b0, c.shape_point_three_scale};
			default: point_frac = FULL_SCALE;
		endcase
	endfunction

	// base current times point fraction
	always_comb begin
		base = 13'({5'h00, amp} * {8'h00, peak});
		frac = custom ? point_frac(point, coef) : FULL_SCALE;
		prod = {9'h000, base} * {13'h0000, frac};
		nxt_level = prod[20:8];
	end

	// output register
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			level_ff <= 13'h0000;
		end else begin
			level_ff <= nxt_level;
		end
	end

	assign level = level_ff;

	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);

	point_zero_a: assert property (custom && point == 3'h0 |=> level_ff == 13'h0000)
		else $error("point 0 not at zero current");
	point_peak_a: assert property (custom && point == 3'h4 |=> level_ff == $past(base))
		else $error("point 4 not at full current");
	point_mirror_a: assert property (custom && point == 3'h5 ##1 custom && point == 3'h5 && $stable(coef)
		&& $stable(amp) && $stable(peak)
		|=> level_ff == 13'(({9'h000, $past(base)} * {14'h0000, $past(coef.shape_point_three_scale)}) >> 8))
		else $error("point 5 not mirrored from point 3");
endmodule

// File: rtl/haptic_drive_waveform_control.sv
// haptic drive control: apb registers, playback sequencer, shape and phase
`timescale 1ns/100ps
//
// Function
// - resistance readout is meas_code captured as is at the end of measurement
// - hold plus measure-disable skips resistance measurement
// - amplitude loop lowers current on large back-emf
// - memory modes take period from frame data
// - period updates apply at next half-period
// - eight points per half-period, points 5..7 mirror 3..1
// - point 0 zero, point 4 full, scaled between
// - shape scales reset to sine values
// - embedded mode clears faults entering inactive
// - fault stops drive, loop off, inactive, retry
// - phase flag toggles every half-period start
// - amplitude and frequency paths are separate
// - event flags write-one-clear and maskable
module haptic_drive_waveform_control (
	// clock and reset
	input  wire logic               ref_clk,
	input  wire logic               rst,
	// apb slave
	input  wire logic               psel,
	input  wire logic               penable,
	input  wire logic               pwrite,
	input  wire logic [7:0]         paddr,
	input  wire logic [31:0]        pwdata,
	output logic [31:0]             prdata,
	output logic                    pready,
	output logic                    pslverr,
	// pins from outside the clock domain
	input  wire logic               play_pin,
	input  wire logic               short_pin,
	// same-clock sense and stream inputs
	input  wire logic [7:0]         bemf_level,
	input  wire logic [9:0]         meas_code,
	input  wire logic [7:0]         pwm_amp,
	input  wire haptic_pkg::frame_s frame,
	// output stage and interrupt
	output haptic_pkg::drive_s      drive,
	output logic                    irq
);
	import haptic_pkg::*;

	ctrl_s        ctrl_ff, nxt_ctrl;
	shape_s       shape_ff, nxt_shape;
	drive_state_e st_ff, nxt_st;
	drive_s       drive_ff, nxt_drive;
	logic [15:0]  period_ff, nxt_period, per_src;
	logic [7:0]   amp_ff, nxt_amp, amp_src, reduce_ff, nxt_reduce;
	logic [9:0]   resist_ff, nxt_resist, factor_ff, nxt_factor;
	logic [2:0]   stat_ff, nxt_stat, mask_ff, nxt_mask, ev, w1c;
	logic [31:0]  prdata_ff, nxt_prdata, rd_val;
	logic         pready_ff, nxt_pready, pslverr_ff, nxt_pslverr, irq_ff, nxt_irq;
	logic         phase_ff, nxt_phase, idle_entry_ff, nxt_idle_entry;
	logic         play_prev_ff, play_ok, play_rise, short_ok, short_evt;
	logic         acc, wr, skip, meas_end, meas_take, embed_clr;
	logic         half_start, hp_pol;
	logic [2:0]   point_idx;
	logic [12:0]  shape_level, cut;
	logic [1:0]   pin_in, pin_ok;

	// three-stage synchronisers, a change counts when stages two and three agree
	assign pin_in = {short_pin, play_pin};
	genvar g;
	for (g = 0; g < 2; g++) begin : g_sync
		logic [2:0] sync_ff, nxt_sync;
		logic       ok_ff, nxt_ok;
		always_comb begin
			nxt_sync = {sync_ff[1:0], pin_in[g]};
			nxt_ok = (sync_ff[2] == sync_ff[1]) ? sync_ff[2] : ok_ff;
		end
		always_ff @(posedge ref_clk) begin
			if (rst) begin
				sync_ff <= 3'h0;
				ok_ff <= 1'b0;
			end else begin
				sync_ff <= nxt_sync;
				ok_ff <= nxt_ok;
			end
		end
		assign pin_ok[g] = ok_ff;
	end
	assign play_ok = pin_ok[0];
	assign short_ok = pin_ok[1];

	// register address check, shared by write decode and error answer
	function automatic logic addr_mapped(input logic [7:0] a);
		case (a)
			OFS_CTRL, OFS_PERIOD, OFS_AMP, OFS_SHAPE, OFS_RESIST,
			OFS_FACTOR, OFS_STATUS, OFS_IRQ_STAT, OFS_IRQ_MASK: addr_mapped = 1'b1;
			default: addr_mapped = 1'b0;
		endcase
	endfunction

	// read data mux
	always_comb begin
		case (paddr)
			OFS_CTRL:     rd_val = {17'h00000, ctrl_ff};
			OFS_PERIOD:   rd_val = {16'h0000, period_ff};
			OFS_AMP:      rd_val = {24'h000000, amp_ff};
			OFS_SHAPE:    rd_val = {8'h00, shape_ff};
			OFS_RESIST:   rd_val = {22'h000000, resist_ff};
			OFS_FACTOR:   rd_val = {22'h000000, factor_ff};
			OFS_STATUS:   rd_val = {28'h0000000, st_ff, phase_ff};
			OFS_IRQ_STAT: rd_val = {29'h00000000, stat_ff};
			OFS_IRQ_MASK: rd_val = {29'h00000000, mask_ff};
			default:      rd_val = 32'h00000000;
		endcase
	end

	// apb handshake: one wait cycle, write and error land with pready
	always_comb begin
		acc = psel & penable;
		wr = acc & pwrite & pready_ff & addr_mapped(paddr);
		nxt_pready = acc & ~pready_ff;
		nxt_pslverr = acc & ~pready_ff & ~addr_mapped(paddr);
		nxt_prdata = (acc & ~pready_ff & ~pwrite) ? rd_val : prdata_ff;
	end

	// software writable registers
	always_comb begin
		nxt_ctrl = ctrl_ff;
		nxt_period = period_ff;
		nxt_amp = amp_ff;
		nxt_shape = shape_ff;
		nxt_mask = mask_ff;
		w1c = 3'h0;
		if (wr) begin
			case (paddr)
				OFS_CTRL:     nxt_ctrl = ctrl_s'(pwdata[14:0]);
				OFS_PERIOD:   nxt_period = pwdata[15:0];
				OFS_AMP:      nxt_amp = pwdata[7:0];
				OFS_SHAPE:    nxt_shape = shape_s'(pwdata[23:0]);
				OFS_IRQ_STAT: w1c = pwdata[2:0];
				OFS_IRQ_MASK: nxt_mask = pwdata[2:0];
				default:      w1c = 3'h0;
			endcase
		end
	end

	// separate amplitude and frequency sources per mode
	always_comb begin
		case (ctrl_ff.play_mode)
			DIRECT_OVERRIDE_MODE:      amp_src = amp_ff;
			MODE_PWM:                  amp_src = pwm_amp;
			REALTIME_MEMORY_PLAYBACK,
			TRIGGERED_MEMORY_PLAYBACK: amp_src = frame.amp;
			default:                   amp_src = 8'h00;
		endcase
		if ((ctrl_ff.play_mode == REALTIME_MEMORY_PLAYBACK || ctrl_ff.play_mode == TRIGGERED_MEMORY_PLAYBACK)
			&& frame.period_valid) begin
			per_src = frame.period;
		end else begin
			per_src = period_ff;
		end
	end

	// playback sequencer, events and measurement
	always_comb begin
		play_rise = play_ok & ~play_prev_ff;
		short_evt = short_ok & (st_ff != ST_IDLE);
		skip = ctrl_ff.drive_factor_hold & ctrl_ff.resistance_measure_disable;
		meas_end = half_start & hp_pol;
		meas_take = (st_ff == ST_MEAS) & meas_end & play_ok & ~short_evt;
		nxt_st = st_ff;
		case (st_ff)
			ST_IDLE: begin
				if (play_rise && ctrl_ff.play_mode != MODE_OFF && (stat_ff & FAULT_BITS) == 3'h0) begin
					nxt_st = skip ? ST_DRIVE : ST_MEAS;
				end
			end
			ST_MEAS: begin
				if (short_evt || !play_ok) begin
					nxt_st = ST_IDLE;
				end else if (meas_end) begin
					nxt_st = ST_DRIVE;
				end
			end
			ST_DRIVE: begin
				if (short_evt || !play_ok) begin
					nxt_st = ST_IDLE;
				end
			end
			default: nxt_st = ST_IDLE;
		endcase
		ev = 3'h0;
		ev[EV_SHORT] = short_evt;
		ev[EV_DONE] = (st_ff != ST_IDLE) & ~play_ok & ~short_evt;
		ev[EV_MEAS] = meas_take;
		nxt_idle_entry = (st_ff != ST_IDLE) && (nxt_st == ST_IDLE);
		nxt_resist = meas_take ? meas_code : resist_ff;
		nxt_factor = (wr && paddr == OFS_FACTOR) ? pwdata[9:0] : factor_ff;
		if (meas_take && !ctrl_ff.drive_factor_hold) begin
			nxt_factor = meas_code;
		end
	end

	// sticky flags: set wins over write-one-clear and embedded clear
	always_comb begin
		embed_clr = ctrl_ff.embedded_mode & idle_entry_ff;
		nxt_stat = (stat_ff & ~w1c & ~(embed_clr ? FAULT_BITS : 3'h0)) | ev;
		nxt_irq = |(nxt_stat & ~nxt_mask);
	end

	// amplitude loop trims current once per half-period, phase flag
	always_comb begin
		nxt_reduce = reduce_ff;
		if (!ctrl_ff.amplitude_loop_enable) begin
			nxt_reduce = 8'h00;
		end else if (half_start) begin
			if (bemf_level > BEMF_LIMIT && reduce_ff != 8'hFF) begin
				nxt_reduce = reduce_ff + 8'h01;
			end else if (bemf_level <= BEMF_LIMIT && reduce_ff != 8'h00) begin
				nxt_reduce = reduce_ff - 8'h01;
			end
		end
		nxt_phase = phase_ff ^ half_start;
	end

	// output stage command, stops at once on fault
	always_comb begin
		cut = {reduce_ff, 5'h00};
		nxt_drive.enable = (nxt_st != ST_IDLE);
		nxt_drive.loop_enable = (nxt_st != ST_IDLE);
		nxt_drive.polarity = hp_pol;
		nxt_drive.level = 13'h0000;
		if (nxt_st != ST_IDLE && shape_level > cut) begin
			nxt_drive.level = shape_level - cut;
		end
	end

	// registers of the block other than the pin synchronisers
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			ctrl_ff <= CTRL_RESET;
			period_ff <= PERIOD_RESET;
			amp_ff <= AMP_RESET;
			shape_ff <= SHAPE_RESET;
			mask_ff <= MASK_RESET;
			stat_ff <= 3'h0;
			st_ff <= ST_IDLE;
			resist_ff <= 10'h000;
			factor_ff <= FACTOR_RESET;
			reduce_ff <= 8'h00;
			phase_ff <= 1'b0;
			idle_entry_ff <= 1'b0;
			play_prev_ff <= 1'b0;
			drive_ff <= drive_s'(16'h0000);
			irq_ff <= 1'b0;
			pready_ff <= 1'b0;
			pslverr_ff <= 1'b0;
			prdata_ff <= 32'h00000000;
		end else begin
			ctrl_ff <= nxt_ctrl;
			period_ff <= nxt_period;
			amp_ff <= nxt_amp;
			shape_ff <= nxt_shape;
			mask_ff <= nxt_mask;
			stat_ff <= nxt_stat;
			st_ff <= nxt_st;
			resist_ff <= nxt_resist;
			factor_ff <= nxt_factor;
			reduce_ff <= nxt_reduce;
			phase_ff <= nxt_phase;
			idle_entry_ff <= nxt_idle_entry;
			play_prev_ff <= play_ok;
			drive_ff <= nxt_drive;
			irq_ff <= nxt_irq;
			pready_ff <= nxt_pready;
			pslverr_ff <= nxt_pslverr;
			prdata_ff <= nxt_prdata;
		end
	end

	// point timer and shape scaling
	half_period_gen u_half (
		.ref_clk      (ref_clk),
		.rst          (rst),
		.run          (st_ff != ST_IDLE),
		.point_cycles (per_src),
		.half_start   (half_start),
		.point_idx    (point_idx),
		.polarity     (hp_pol)
	);

	shape_point u_shape (
		.ref_clk (ref_clk),
		.rst     (rst),
		.custom  (ctrl_ff.custom_shape_select),
		.coef    (shape_ff),
		.point   (point_idx),
		.amp     (amp_src),
		.peak    (ctrl_ff.peak_current_limit),
		.level   (shape_level)
	);

	assign prdata = prdata_ff;
	assign pready = pready_ff;
	assign pslverr = pslverr_ff;
	assign drive = drive_ff;
	assign irq = irq_ff;

	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);

	meas_capture_a: assert property (meas_take |=> resist_ff == $past(meas_code))
		else $error("measured resistance not captured");
	meas_skip_a: assert property ((st_ff == ST_IDLE) ##1 (st_ff == ST_MEAS) |-> !$past(skip))
		else $error("measurement ran although skipped");
	amp_loop_off_a: assert property (!ctrl_ff.amplitude_loop_enable |=> reduce_ff == 8'h00)
		else $error("current trimmed with loop off");
	amp_loop_up_a: assert property (ctrl_ff.amplitude_loop_enable && half_start && bemf_level > BEMF_LIMIT
		&& reduce_ff != 8'hFF |=> reduce_ff == $past(reduce_ff) + 8'h01)
		else $error("current not lowered on large back-emf");
	freq_src_a: assert property (ctrl_ff.play_mode == REALTIME_MEMORY_PLAYBACK && frame.period_valid
		|-> per_src == frame.period)
		else $error("frame period not used");
	amp_src_a: assert property (ctrl_ff.play_mode == DIRECT_OVERRIDE_MODE |-> amp_src == amp_ff)
		else $error("direct amplitude not selected");
	coeff_reset_a: assert property ($fell(rst) |-> shape_ff == SHAPE_RESET)
		else $error("shape scales not at sine reset");
	embed_clear_a: assert property (idle_entry_ff && ctrl_ff.embedded_mode |=> !stat_ff[EV_SHORT])
		else $error("fault not cleared in embedded mode");
	fault_stop_a: assert property (short_evt |=> st_ff == ST_IDLE && !drive_ff.enable && !drive_ff.loop_enable)
		else $error("drive not stopped on fault");
	phase_toggle_a: assert property (half_start |=> phase_ff != $past(phase_ff) ##1 rd_val[0] == phase_ff
		|| paddr != OFS_STATUS)
		else $error("phase flag did not toggle");
	event_set_a: assert property (ev != 3'h0 |=> (stat_ff & $past(ev)) == $past(ev))
		else $error("event lost against clear");
	irq_level_a: assert property (irq_ff == |(stat_ff & ~mask_ff))
		else $error("interrupt not matching unmasked flags");

	cover_fault_c: cover property (short_evt);
	cover_meas_c: cover property (meas_take);
	cover_done_c: cover property (st_ff == ST_DRIVE && !play_ok);
	cover_custom_c: cover property (half_start && ctrl_ff.custom_shape_select && hp_pol);
endmodule

// File: verif/actuator_model.sv
// behavioural actuator beside the output stage: play and fault pins, back-emf and resistance sense
`timescale 1ns/100ps
module actuator_model #(
	parameter logic [9:0] RES_CODE = 10'h2A5
) (
	// clock
	input  wire logic               ref_clk,
	// test control
	input  wire logic               play_req,
	input  wire logic               fault_req,
	// device side
	input  wire haptic_pkg::drive_s drive,
	output logic                    play_pin,
	output logic                    short_pin,
	output logic [7:0]              bemf_level,
	output logic [9:0]              meas_code
);
	import haptic_pkg::*;

	logic [7:0] bemf_ff;

	// pins change a little after the edge, as an unclocked source would
	always @(posedge ref_clk) begin
		play_pin <= #3 play_req;
		short_pin <= #3 fault_req;
	end

	// back-emf follows the drive and decays once it stops
	always @(posedge ref_clk) begin
		bemf_ff <= drive.enable ? drive.level[12:5] : bemf_ff >> 1;
	end
	assign bemf_level = bemf_ff;

	// resistance code is only meaningful while current flows
	assign meas_code = drive.enable ? RES_CODE : ~RES_CODE;

	initial begin
		play_pin = 1'b0;
		short_pin = 1'b0;
		bemf_ff = 8'h00;
	end
endmodule

// File: verif/test_haptic_drive_waveform_control.sv
// self-checking bench: registers, playback, measurement, faults and phase flag
`timescale 1ns/100ps
module test_haptic_drive_waveform_control;
	import haptic_pkg::*;

	typedef struct {logic [31:0] exp; logic [31:0] msk; logic err; string nm;} note_s;
	localparam logic [9:0] RES = 10'h2A5;
	localparam int         PER = 3;

	logic        ref_clk, rst, psel, penable, pwrite, pready, pslverr, irq, play_req, fault_req;
	logic        play_pin, short_pin, ph0;
	logic [7:0]  paddr, bemf_level, pwm_amp;
	logic [9:0]  meas_code;
	logic [31:0] pwdata, prdata, q, r, seed;
	frame_s      frame;
	drive_s      drive;
	note_s       exp_q[$];
	note_s       note;
	int          err_total, checks_done, n;
	logic [7:0]  ra[6] = '{OFS_CTRL, OFS_PERIOD, OFS_SHAPE, OFS_FACTOR, OFS_IRQ_STAT, OFS_IRQ_MASK};
	logic [31:0] rv[6] = '{32'h0, 32'h100, 32'hECB461, 32'h0, 32'h0, 32'h0};

	haptic_drive_waveform_control haptic_drive_waveform_control_inst (.ref_clk(ref_clk), .rst(rst),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .play_pin(play_pin), .short_pin(short_pin),
		.bemf_level(bemf_level), .meas_code(meas_code), .pwm_amp(pwm_amp), .frame(frame), .drive(drive),
		.irq(irq));
	actuator_model #(.RES_CODE(RES)) actuator_model_inst (.ref_clk(ref_clk), .play_req(play_req),
		.fault_req(fault_req), .drive(drive), .play_pin(play_pin), .short_pin(short_pin),
		.bemf_level(bemf_level), .meas_code(meas_code));

	// clock
	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end

	// random stream inputs, short periods keep half-periods brief
	always @(posedge ref_clk) begin
		r = $random(seed);
		frame.period <= {12'h000, r[3:0]};
		frame.period_valid <= r[4];
		frame.amp <= r[15:8];
		pwm_amp <= r[23:16];
	end

	// compares every completed transfer against the oldest note
	always @(posedge ref_clk) begin
		if (psel && penable && pready) begin
			note = exp_q.pop_front();
			checks_done++;
			if (((prdata & note.msk) !== note.exp) || (pslverr !== note.err)) begin
				err_total++;
				$display("[FAIL] %s expected %h/%b seen %h/%b", note.nm, note.exp, note.err, prdata, pslverr);
			end
		end
	end

	task automatic end_of_test;
		if (err_total == 0 && checks_done > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	task automatic see(input string nm, input logic e, input logic s);
		checks_done++;
		if (s !== e) begin
			err_total++;
			$display("[FAIL] %s expected %b seen %b", nm, e, s);
		end
	endtask

	// one apb transfer, held until pready is sampled high
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [31:0] e,
		input logic [31:0] m, input logic er, input string nm);
		int k;
		k = 0;
		exp_q.push_back('{e & m, m, er, nm});
		@(posedge ref_clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		do begin
			@(posedge ref_clk);
			k++;
		end while (pready !== 1'b1 && k < 30);
		q = prdata;
		if (k >= 30) err_total++;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m, input string nm);
		apb(1'b0, a, 32'h0, e, m, 1'b0, nm);
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d, 32'h0, 32'h0, 1'b0, "write");
	endtask

	task automatic wait_en(input logic v);
		n = 0;
		while (drive.enable !== v && n < 300) begin
			@(posedge ref_clk);
			n++;
		end
		see("drive.enable", v, drive.enable);
		see("drive.loop_enable", v, drive.loop_enable);
		if (!v) see("drive.level", 1'b1, drive.level === 13'h0000);
	endtask

	task automatic play(input logic [31:0] ctrl);
		wr(OFS_CTRL, ctrl);
		play_req <= 1'b1;
		wait_en(1'b1);
	endtask

	// watchdog
	initial begin
		repeat (40000) @(posedge ref_clk);
		err_total++;
		end_of_test();
	end

	initial begin
		seed = 32'h5A70C13F;
		{rst, psel, penable, pwrite, play_req, fault_req} = 6'h20;
		{paddr, pwdata, pwm_amp, frame, err_total, checks_done} = '0;
		repeat (4) @(posedge ref_clk);
		rst <= 1'b0;
		// reset values and two unmapped places
		for (int i = 0; i < 6; i++) rd(ra[i], rv[i], 32'hFFFFFFFF, "reset value");
		rd(OFS_STATUS, 32'h2, 32'hE, "idle state");
		apb(1'b0, 8'h40, 32'h0, 32'h0, 32'hFFFFFFFF, 1'b1, "unmapped read");
		apb(1'b1, 8'h44, 32'h5, 32'h0, 32'h0, 1'b1, "unmapped write");
		// direct mode, custom shape, measurement skipped
		wr(OFS_PERIOD, PER);
		wr(OFS_AMP, $random(seed));
		play(32'hB20 | ($random(seed) & 32'h1F));
		rd(OFS_STATUS, 32'h8, 32'hE, "drive without measuring");
		rd(OFS_STATUS, 32'h0, 32'h0, "phase");
		ph0 = q[0];
		n = 0;
		do begin
			rd(OFS_STATUS, 32'h0, 32'h0, "phase");
			n++;
		end while (q[0] === ph0 && n < 40);
		see("phase toggled", 1'b1, q[0] !== ph0);
		wr(OFS_AMP, $random(seed));
		wr(OFS_PERIOD, PER + 1);
		play_req <= 1'b0;
		wait_en(1'b0);
		rd(OFS_IRQ_STAT, 32'h2, 32'h7, "done flag");
		see("irq", 1'b1, irq);
		wr(OFS_IRQ_STAT, 32'h2);
		repeat (2) @(posedge ref_clk);
		see("irq", 1'b0, irq);
		// pwm mode with measurement, amplitude loop on, measurement event masked
		wr(OFS_IRQ_MASK, 32'h4);
		play(32'h440 | ($random(seed) & 32'h1F));
		repeat (3 * 8 * (PER + 2)) @(posedge ref_clk);
		play_req <= 1'b0;
		wait_en(1'b0);
		rd(OFS_RESIST, {22'h0, RES}, 32'h3FF, "resistance");
		rd(OFS_FACTOR, {22'h0, RES}, 32'h3FF, "drive factor");
		rd(OFS_IRQ_STAT, 32'h6, 32'h7, "done and measure");
		wr(OFS_IRQ_STAT, 32'h2);
		repeat (2) @(posedge ref_clk);
		see("masked irq", 1'b0, irq);
		wr(OFS_IRQ_STAT, 32'h4);
		wr(OFS_IRQ_MASK, 32'h0);
		// fault in memory playback, then a refused start
		play(32'h60);
		fault_req <= 1'b1;
		wait_en(1'b0);
		rd(OFS_IRQ_STAT, 32'h1, 32'h1, "short flag");
		rd(OFS_STATUS, 32'h2, 32'hE, "inactive after fault");
		fault_req <= 1'b0;
		play_req <= 1'b0;
		repeat (6) @(posedge ref_clk);
		play_req <= 1'b1;
		repeat (12) @(posedge ref_clk);
		see("refused start", 1'b0, drive.enable);
		play_req <= 1'b0;
		wr(OFS_IRQ_STAT, 32'h7);
		// embedded mode clears the fault by itself and retries
		play(32'h1080);
		fault_req <= 1'b1;
		wait_en(1'b0);
		repeat (4) @(posedge ref_clk);
		rd(OFS_IRQ_STAT, 32'h0, 32'h7, "embedded clear");
		see("irq", 1'b0, irq);
		fault_req <= 1'b0;
		play_req <= 1'b0;
		repeat (6) @(posedge ref_clk);
		play_req <= 1'b1;
		wait_en(1'b1);
		play_req <= 1'b0;
		wait_en(1'b0);
		end_of_test();
	end
endmodule
